// File: common/uadc_pkg.sv
// constants for the usb attach/detach control block
// assumes one 200 MHz clock and an 8-bit register port with 4-bit addresses
package uadc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int LINE_COUNT = 6;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;

    // programmable io lines are numbered from this value upward
    localparam logic [2:0] LINE_BASE = 3'h2;
    localparam logic [2:0] SEL_NONE = 3'h0;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PULL_PIN = 4'h1;
    localparam logic [3:0] OFS_UNPLUG_PIN = 4'h2;
    localparam logic [3:0] OFS_WAKE_PIN = 4'h3;
    localparam logic [3:0] OFS_GP_DIR = 4'h4;
    localparam logic [3:0] OFS_GP_OUT = 4'h5;
    localparam logic [3:0] OFS_GP_IN = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CTRL_READY = 0;
    localparam int CTRL_EXT_SRC = 1;
    localparam int CTRL_EP_SEL = 2;
    localparam int CTRL_WAKE_REQ = 3;

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int STAT_DETACHED = 0;
    localparam int STAT_PULL_ON = 1;
    localparam int STAT_WAKE = 2;
    localparam int STAT_EP = 3;
    localparam int STAT_FULL_SPEED = 4;
    localparam int STAT_RESUME_BLK = 5;
    localparam int STAT_LINE_LO = 6;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [5:0] LINES_ALL = 6'h3F;
    localparam logic [5:0] LINES_NONE = 6'h00;
    localparam logic EXT_SRC_RST = 1'b0;
    localparam logic EP_SET_BT = 1'b0;
    localparam logic EP_SET_AUDIO = 1'b1;
    localparam logic SPEED_FULL = 1'b1;
    localparam int FULL_SPEED_HZ = 12_000_000;

endpackage

// File: hdl/uadc_top.sv
// usb attach/detach control: pull-up selection, out-of-band detach and wake lines
// assumes a serial engine on MCLK drives the tx inputs and pins arrive asynchronous
//
// Overview of operation
// - The usb port is a 12 Mbit/s full-speed port driving the cable lines directly.
// - The port only drives the data lines when the serial engine answers, never on its own.
// - The D+ pull-up is switched on only once software marks the port ready to enumerate.
// - A control bit picks the internal pull-up or an external one on a pin; internal by default.
// - The unplug input and the wake output sit on the io line whose number is selected.
// - While unplug is high both data lines float and the pull-up is off.
// - When unplug goes low the pull-up returns and the port waits to be enumerated.
// - The wake output goes high on request, but only while unplug is asserted.
// - While unplugged no in-band resume is sent on the cable.
// - Against a high-speed host the port stays at the full-speed rate.
// - One of two endpoint sets is exposed: the wireless controller set or the audio set.
// - After reset every io line is an input with its weak pull-down on.
`timescale 1ns/1ps

module uadc_top (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // serial engine side
    input wire logic SIE_TX_EN,
    input wire logic SIE_TX_PLUS,
    input wire logic SIE_TX_MINUS,
    input wire logic SIE_RESUME,
    output logic SIE_RX_PLUS,
    output logic SIE_RX_MINUS,
    output logic EP_SET,
    // usb data pair
    input wire logic USB_PLUS_IN,
    input wire logic USB_MINUS_IN,
    output logic USB_PLUS_OUT,
    output logic USB_MINUS_OUT,
    output logic USB_OE_N,
    output logic USB_PULLUP_INT,
    // programmable io lines
    input wire logic [5:0] IOL_IN,
    output logic [5:0] IOL_OUT,
    output logic [5:0] IOL_OE_N,
    output logic [5:0] IOL_PULLDN
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] iol_s1;
        logic [5:0] iol_s2;
        logic [1:0] usb_s1;
        logic [1:0] usb_s2;
        logic ready;
        logic ext_src;
        logic ep_sel;
        logic wake_req;
        logic [2:0] pull_pin;
        logic [2:0] unplug_pin;
        logic [2:0] wake_pin;
        logic [5:0] gp_dir;
        logic [5:0] gp_out;
        logic detached;
        logic pull_on;
        logic wake_o;
        logic resume_blk;
        logic ep_active;
        logic [5:0] iol_out;
        logic [5:0] iol_oe_n;
        logic [5:0] iol_pdn;
        logic usb_plus_o;
        logic usb_minus_o;
        logic usb_oe_n;
        logic pull_int;
        logic [7:0] rdata;
    } uadc_state_s;

    localparam uadc_state_s ST_RST = '{
        iol_s1: uadc_pkg::LINES_NONE,
        iol_s2: uadc_pkg::LINES_NONE,
        usb_s1: 2'h0,
        usb_s2: 2'h0,
        ready: 1'b0,
        ext_src: uadc_pkg::EXT_SRC_RST,
        ep_sel: uadc_pkg::EP_SET_BT,
        wake_req: 1'b0,
        pull_pin: uadc_pkg::SEL_NONE,
        unplug_pin: uadc_pkg::SEL_NONE,
        wake_pin: uadc_pkg::SEL_NONE,
        gp_dir: uadc_pkg::LINES_NONE,
        gp_out: uadc_pkg::LINES_NONE,
        detached: 1'b0,
        pull_on: 1'b0,
        wake_o: 1'b0,
        resume_blk: 1'b0,
        ep_active: uadc_pkg::EP_SET_BT,
        iol_out: uadc_pkg::LINES_NONE,
        iol_oe_n: uadc_pkg::LINES_ALL,
        iol_pdn: uadc_pkg::LINES_ALL,
        usb_plus_o: 1'b0,
        usb_minus_o: 1'b0,
        usb_oe_n: 1'b1,
        pull_int: 1'b0,
        rdata: 8'h00
    };

    uadc_state_s st;
    uadc_state_s nxt_st;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [2:0] line_no;
        logic unplug_hit;
        logic [7:0] status;
        line_no = 3'h0;
        unplug_hit = 1'b0;
        status = 8'h00;
        nxt_st = st;

        // two-stage synchronisers for pins
        nxt_st.iol_s1 = IOL_IN;
        nxt_st.iol_s2 = st.iol_s1;
        nxt_st.usb_s1 = {USB_PLUS_IN, USB_MINUS_IN};
        nxt_st.usb_s2 = st.usb_s1;

        // register writes
        if (WR)
        begin
            case (ADDR)
                uadc_pkg::OFS_CTRL:
                begin
                    nxt_st.ready = WDATA[uadc_pkg::CTRL_READY];
                    nxt_st.ext_src = WDATA[uadc_pkg::CTRL_EXT_SRC];
                    nxt_st.ep_sel = WDATA[uadc_pkg::CTRL_EP_SEL];
                    nxt_st.wake_req = WDATA[uadc_pkg::CTRL_WAKE_REQ];
                end
                uadc_pkg::OFS_PULL_PIN: nxt_st.pull_pin = WDATA[2:0];
                uadc_pkg::OFS_UNPLUG_PIN: nxt_st.unplug_pin = WDATA[2:0];
                uadc_pkg::OFS_WAKE_PIN: nxt_st.wake_pin = WDATA[2:0];
                uadc_pkg::OFS_GP_DIR: nxt_st.gp_dir = WDATA[5:0];
                uadc_pkg::OFS_GP_OUT: nxt_st.gp_out = WDATA[5:0];
                default: nxt_st.gp_out = st.gp_out;
            endcase
        end

        // per-line function routing
        for (int i = 0; i < uadc_pkg::LINE_COUNT; i++)
        begin
            line_no = 3'(i) + uadc_pkg::LINE_BASE;
            if (st.unplug_pin == line_no && st.iol_s2[i])
            begin
                unplug_hit = 1'b1;
            end
            if (st.wake_pin == line_no)
            begin
                nxt_st.iol_oe_n[i] = 1'b0;
                nxt_st.iol_out[i] = st.wake_o;
                nxt_st.iol_pdn[i] = 1'b0;
            end
            else if (st.ext_src && st.pull_pin == line_no)
            begin
                // external pull-up: drive high when on, float when off
                nxt_st.iol_oe_n[i] = ~st.pull_on;
                nxt_st.iol_out[i] = st.pull_on;
                nxt_st.iol_pdn[i] = 1'b0;
            end
            else if (st.unplug_pin == line_no)
            begin
                nxt_st.iol_oe_n[i] = 1'b1;
                nxt_st.iol_out[i] = 1'b0;
                nxt_st.iol_pdn[i] = 1'b1;
            end
            else
            begin
                nxt_st.iol_oe_n[i] = ~st.gp_dir[i];
                nxt_st.iol_out[i] = st.gp_out[i] & st.gp_dir[i];
                nxt_st.iol_pdn[i] = ~st.gp_dir[i];
            end
        end

        // attach state
        nxt_st.detached = unplug_hit;
        nxt_st.pull_on = st.ready & ~st.detached;
        nxt_st.pull_int = st.ready & ~st.detached & ~st.ext_src;
        nxt_st.wake_o = st.wake_req & st.detached;

        // endpoint set only changes while not announced to the host
        if (!st.pull_on)
        begin
            nxt_st.ep_active = st.ep_sel;
        end

        // data pair: answer only, full-speed polarity on the D+ pull-up side
        if (st.detached)
        begin
            nxt_st.usb_oe_n = 1'b1;
            nxt_st.usb_plus_o = 1'b0;
            nxt_st.usb_minus_o = 1'b0;
        end
        else if (SIE_TX_EN)
        begin
            nxt_st.usb_oe_n = 1'b0;
            nxt_st.usb_plus_o = SIE_TX_PLUS;
            nxt_st.usb_minus_o = SIE_TX_MINUS;
        end
        else if (SIE_RESUME)
        begin
            // in-band resume is a K state
            nxt_st.usb_oe_n = 1'b0;
            nxt_st.usb_plus_o = 1'b0;
            nxt_st.usb_minus_o = 1'b1;
        end
        else
        begin
            nxt_st.usb_oe_n = 1'b1;
            nxt_st.usb_plus_o = 1'b0;
            nxt_st.usb_minus_o = 1'b0;
        end

        // status view
        status[uadc_pkg::STAT_DETACHED] = st.detached;
        status[uadc_pkg::STAT_PULL_ON] = st.pull_on;
        status[uadc_pkg::STAT_WAKE] = st.wake_o;
        status[uadc_pkg::STAT_EP] = st.ep_active;
        status[uadc_pkg::STAT_FULL_SPEED] = uadc_pkg::SPEED_FULL;
        status[uadc_pkg::STAT_RESUME_BLK] = st.resume_blk;
        status[uadc_pkg::STAT_LINE_LO +: 2] = st.usb_s2;

        // refused resume flag: cleared by status read, a new refusal wins
        if (RD && ADDR == uadc_pkg::OFS_STATUS)
        begin
            nxt_st.resume_blk = 1'b0;
        end
        if (st.detached && SIE_RESUME)
        begin
            nxt_st.resume_blk = 1'b1;
        end

        // register reads, data in the following cycle only
        nxt_st.rdata = 8'h00;
        if (RD)
        begin
            case (ADDR)
                uadc_pkg::OFS_CTRL: nxt_st.rdata = {4'h0, st.wake_req, st.ep_sel,
                    st.ext_src, st.ready};
                uadc_pkg::OFS_PULL_PIN: nxt_st.rdata = {5'h00, st.pull_pin};
                uadc_pkg::OFS_UNPLUG_PIN: nxt_st.rdata = {5'h00, st.unplug_pin};
                uadc_pkg::OFS_WAKE_PIN: nxt_st.rdata = {5'h00, st.wake_pin};
                uadc_pkg::OFS_GP_DIR: nxt_st.rdata = {2'h0, st.gp_dir};
                uadc_pkg::OFS_GP_OUT: nxt_st.rdata = {2'h0, st.gp_out};
                uadc_pkg::OFS_GP_IN: nxt_st.rdata = {2'h0, st.iol_s2};
                uadc_pkg::OFS_STATUS: nxt_st.rdata = status;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            st <= ST_RST;
        end
        else
        begin
            st <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RDATA = st.rdata;
    assign SIE_RX_PLUS = st.usb_s2[1];
    assign SIE_RX_MINUS = st.usb_s2[0];
    assign EP_SET = st.ep_active;
    assign USB_PLUS_OUT = st.usb_plus_o;
    assign USB_MINUS_OUT = st.usb_minus_o;
    assign USB_OE_N = st.usb_oe_n;
    assign USB_PULLUP_INT = st.pull_int;
    assign IOL_OUT = st.iol_out;
    assign IOL_OE_N = st.iol_oe_n;
    assign IOL_PULLDN = st.iol_pdn;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence s_unplug_seen;
        st.unplug_pin == uadc_pkg::LINE_BASE && st.iol_s2[0];
    endsequence

    sequence s_floated;
        st.detached ##1 (USB_OE_N && !USB_PULLUP_INT);
    endsequence

    property p_unplug_route;
        s_unplug_seen |=> s_floated;
    endproperty
    a_unplug_route: assert property (p_unplug_route) else $error("unplug pin ignored");

    property p_detach_float;
        st.detached |=> USB_OE_N && !USB_PULLUP_INT && !st.pull_on;
    endproperty
    a_detach_float: assert property (p_detach_float) else $error("lines driven while unplugged");

    property p_pull_ready;
        !st.ready |=> !USB_PULLUP_INT && !st.pull_on;
    endproperty
    a_pull_ready: assert property (p_pull_ready) else $error("pull-up on before ready");

    property p_pull_source;
        st.ext_src |=> !USB_PULLUP_INT;
    endproperty
    a_pull_source: assert property (p_pull_source) else $error("internal pull-up with ext source");

    property p_reconnect;
        ($fell(st.detached) && st.ready && !st.ext_src)
            ##1 (st.ready && !st.ext_src && !st.detached) |=> USB_PULLUP_INT;
    endproperty
    a_reconnect: assert property (p_reconnect) else $error("no reconnect after unplug low");

    property p_wake_only_detached;
        st.wake_o |-> $past(st.detached) && $past(st.wake_req);
    endproperty
    a_wake_only_detached: assert property (p_wake_only_detached) else $error("wake while attached");

    property p_no_inband_resume;
        st.detached && SIE_RESUME |=> USB_OE_N && st.resume_blk;
    endproperty
    a_no_inband_resume: assert property (p_no_inband_resume) else $error("resume sent unplugged");

    property p_slave_only;
        !USB_OE_N |-> $past(SIE_TX_EN || SIE_RESUME) && !$past(st.detached);
    endproperty
    a_slave_only: assert property (p_slave_only) else $error("pair driven unasked");

    property p_ep_stable;
        st.pull_on && $past(st.pull_on) |-> $stable(EP_SET);
    endproperty
    a_ep_stable: assert property (p_ep_stable) else $error("endpoint set changed while on");

    property p_reset_lines;
        $rose(RESET_N) |-> IOL_OE_N == uadc_pkg::LINES_ALL && IOL_PULLDN == uadc_pkg::LINES_ALL;
    endproperty
    a_reset_lines: assert property (p_reset_lines) else $error("io lines not inputs at reset");

endmodule

// File: verif/uadc_host_model.sv
// far side model: usb host with its line pull-downs, plus host detach/wake logic
// assumes the bench drives detach and mirrors the line selects written to the block
`timescale 1ns/1ps

module uadc_host_model (
    // clock
    input wire logic clk,
    // host detach and wake logic
    input wire logic detach,
    input wire logic [2:0] unplug_sel,
    input wire logic [2:0] pull_sel,
    input wire logic [2:0] wake_sel,
    output logic wake_seen,
    // usb pair as seen by the host
    input wire logic oe_n,
    input wire logic plus_out,
    input wire logic minus_out,
    input wire logic pullup_int,
    output logic plus_in,
    output logic minus_in,
    // io lines
    input wire logic [5:0] iol_out,
    input wire logic [5:0] iol_oe_n,
    input wire logic [5:0] iol_pulldn,
    output logic [5:0] iol_in
);
    logic [5:0] flt = 6'h15;
    logic ext_hi;

    // floating lines show a changing pattern, never the last value
    always_ff @(posedge clk)
        flt <= ~flt;

    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (!iol_oe_n[i])
                iol_in[i] = iol_out[i];
            else if (unplug_sel == 3'(i + 2))
                iol_in[i] = detach;
            else if (iol_pulldn[i])
                iol_in[i] = 1'b0;
            else
                iol_in[i] = flt[i];
        end
        ext_hi = (pull_sel >= 3'h2) && !iol_oe_n[pull_sel - 3'h2] && iol_out[pull_sel - 3'h2];
        wake_seen = (wake_sel >= 3'h2) ? iol_in[wake_sel - 3'h2] : 1'b0;
        // host pull-downs hold the pair low; a pulled D+ means full speed
        plus_in = !oe_n ? plus_out : (pullup_int | ext_hi);
        minus_in = !oe_n ? minus_out : 1'b0;
    end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the usb attach/detach control block
// assumes the host model on the far side and the register port of the block
`timescale 1ns/1ps

module tb_top;
    logic mclk, reset_n, wr, rd, tx_en, tx_p, tx_m, resume, detach;
    logic rx_p, rx_m, ep_set, p_in, m_in, p_out, m_out, oe_n, pull_int, wake_seen;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [5:0] iol_in, iol_out, iol_oe_n, iol_pd;
    logic [2:0] un_sel, pu_sel, wk_sel;
    int fails, compares, u, w;
    integer seed, r;

    uadc_top dut (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SIE_TX_EN(tx_en), .SIE_TX_PLUS(tx_p), .SIE_TX_MINUS(tx_m),
        .SIE_RESUME(resume), .SIE_RX_PLUS(rx_p), .SIE_RX_MINUS(rx_m), .EP_SET(ep_set),
        .USB_PLUS_IN(p_in), .USB_MINUS_IN(m_in), .USB_PLUS_OUT(p_out),
        .USB_MINUS_OUT(m_out), .USB_OE_N(oe_n), .USB_PULLUP_INT(pull_int),
        .IOL_IN(iol_in), .IOL_OUT(iol_out), .IOL_OE_N(iol_oe_n), .IOL_PULLDN(iol_pd));

    uadc_host_model host (.clk(mclk), .detach(detach), .unplug_sel(un_sel),
        .pull_sel(pu_sel), .wake_sel(wk_sel), .wake_seen(wake_seen), .oe_n(oe_n),
        .plus_out(p_out), .minus_out(m_out), .pullup_int(pull_int), .plus_in(p_in),
        .minus_in(m_in), .iol_out(iol_out), .iol_oe_n(iol_oe_n), .iol_pulldn(iol_pd),
        .iol_in(iol_in));

    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic end_sim;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic wait_pin(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // status image: detached, pull-up, wake, endpoint set, resume refused, D+
    function automatic logic [7:0] st(input logic dt, pl, wk, ep, bl, dp);
        return {dp, 1'b0, bl, uadc_pkg::SPEED_FULL, ep, wk, pl, dt};
    endfunction

    // pair drive from engine inputs {resume, minus, plus, enable}: {oe_n, D+, D-}
    function automatic logic [2:0] pair(input logic [3:0] s);
        if (s[0])
            return {1'b0, s[1], s[2]};
        if (s[3])
            return 3'b001;
        return 3'b100;
    endfunction

    initial
    begin
        #50000;
        fails++;
        end_sim;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h0356;
        {wr, rd, tx_en, tx_p, tx_m, resume, detach, reset_n} = 8'h00;
        {addr, wdata, un_sel, pu_sel, wk_sel} = 21'h0;
        fails = 0;
        compares = 0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        chk({2'h0, iol_oe_n}, 8'h3F);
        chk({2'h0, iol_pd}, 8'h3F);
        chk({5'h0, oe_n, pull_int, ep_set}, 8'h04);
        chk_rd(uadc_pkg::OFS_CTRL, uadc_pkg::CTRL_RST);
        chk_rd(uadc_pkg::OFS_STATUS, st(0, 0, 0, 0, 0, 0));
        wait_pin(1);
        chk(rdata, 8'h00);
        wr_reg(uadc_pkg::OFS_STATUS, 8'hFF);
        chk_rd(uadc_pkg::OFS_STATUS, st(0, 0, 0, 0, 0, 0));
        for (int a = 8; a < 16; a++)
            chk_rd(4'(a), 8'h00);
        $display("test reset done");

        for (int e = 0; e < 2; e++)
        begin
            wr_reg(uadc_pkg::OFS_CTRL, {5'h0, e[0], 2'h0});
            wait_pin(2);
            chk({7'h0, ep_set}, {7'h0, e[0]});
        end
        wr_reg(uadc_pkg::OFS_CTRL, 8'h05);
        #1;
        chk({7'h0, pull_int}, 8'h00);
        wait_pin(1);
        chk({7'h0, pull_int}, 8'h01);
        wr_reg(uadc_pkg::OFS_CTRL, 8'h01);
        wait_pin(4);
        chk({7'h0, ep_set}, 8'h01);
        chk_rd(uadc_pkg::OFS_STATUS, st(0, 1, 0, 1, 0, 1));
        $display("test attach done");

        for (int i = 0; i < 16; i++)
        begin
            r = $random(seed);
            @(posedge mclk);
            {resume, tx_m, tx_p, tx_en} <= r[3:0];
            wait_pin(1);
            d = {5'h0, pair(r[3:0])};
            chk({5'h0, oe_n, p_out, m_out}, d);
            wait_pin(2);
            chk({6'h0, rx_p, rx_m}, d[2] ? 8'h02 : {6'h0, d[1:0]});
        end
        @(posedge mclk);
        {resume, tx_en} <= 2'b00;
        wait_pin(3);
        chk_rd(uadc_pkg::OFS_STATUS, st(0, 1, 0, 1, 0, 1));
        $display("test engine done");

        for (u = 2; u < 8; u++)
        begin
            w = (u == 7) ? 2 : u + 1;
            un_sel = 3'(u);
            wk_sel = 3'(w);
            wr_reg(uadc_pkg::OFS_UNPLUG_PIN, 8'(u));
            wr_reg(uadc_pkg::OFS_WAKE_PIN, 8'(w));
            wr_reg(uadc_pkg::OFS_CTRL, 8'h09);
            wait_pin(6);
            chk({7'h0, wake_seen}, 8'h00);
            chk({6'h0, iol_oe_n[u - 2], iol_pd[u - 2]}, 8'h03);
            @(posedge mclk);
            detach <= 1'b1;
            wait_pin(6);
            chk({6'h0, oe_n, pull_int}, 8'h02);
            chk({7'h0, wake_seen}, 8'h01);
            @(posedge mclk);
            tx_en <= 1'b1;
            resume <= 1'b1;
            wait_pin(2);
            chk({7'h0, oe_n}, 8'h01);
            @(posedge mclk);
            tx_en <= 1'b0;
            wait_pin(1);
            @(posedge mclk);
            resume <= 1'b0;
            chk_rd(uadc_pkg::OFS_STATUS, st(1, 0, 1, 0, 1, 0));
            chk_rd(uadc_pkg::OFS_STATUS, st(1, 0, 1, 0, 0, 0));
            @(posedge mclk);
            detach <= 1'b0;
            wait_pin(6);
            chk({6'h0, oe_n, pull_int}, 8'h03);
            chk({7'h0, wake_seen}, 8'h00);
        end
        $display("test detach done");

        wr_reg(uadc_pkg::OFS_UNPLUG_PIN, 8'h00);
        wr_reg(uadc_pkg::OFS_WAKE_PIN, 8'h00);
        {un_sel, wk_sel} = 6'h00;
        r = $random(seed);
        u = 2 + (r[7:0] % 6);
        pu_sel = 3'(u);
        wr_reg(uadc_pkg::OFS_PULL_PIN, 8'(u));
        wr_reg(uadc_pkg::OFS_CTRL, 8'h03);
        wait_pin(3);
        chk({5'h0, pull_int, iol_oe_n[u - 2], iol_out[u - 2]}, 8'h01);
        chk_rd(uadc_pkg::OFS_STATUS, st(0, 1, 0, 0, 0, 1));
        wr_reg(uadc_pkg::OFS_CTRL, 8'h02);
        wait_pin(3);
        chk({6'h0, iol_oe_n[u - 2], iol_pd[u - 2]}, 8'h02);
        $display("test external pull-up done");

        wr_reg(uadc_pkg::OFS_PULL_PIN, 8'h00);
        pu_sel = 3'h0;
        r = $random(seed);
        wr_reg(uadc_pkg::OFS_GP_DIR, 8'h3F);
        wr_reg(uadc_pkg::OFS_GP_OUT, {2'h0, r[5:0]});
        wait_pin(4);
        chk({2'h0, iol_out}, {2'h0, r[5:0]});
        chk_rd(uadc_pkg::OFS_GP_IN, {2'h0, r[5:0]});
        $display("test gpio done");
        end_sim;
    end
endmodule
